// *** inc/cpc_regs.svh ***
// constants for the configuration protect block
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// ----------------------------------------------------------------
// configuration word indices on the programming port
// ----------------------------------------------------------------
`define CPC_IDX_CFG4L     4'h0
`define CPC_IDX_CODE_LOCK 4'h1
`define CPC_IDX_WR_LOCK   4'h2
`define CPC_IDX_TRL_LOW   4'h3
`define CPC_IDX_TRL_HIGH  4'h4
`define CPC_IDX_PART_LOW  4'h5
`define CPC_IDX_PART_HIGH 4'h6

// ----------------------------------------------------------------
// implemented-bit masks, a 1 where a choice can be made
// ----------------------------------------------------------------
`define CPC_MASK_CFG4L    8'h34
`define CPC_MASK_LOCK     8'h41
`define CPC_MASK_TRL_LOW  8'h01
`define CPC_MASK_TRL_HIGH 8'h40

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CPC_BIT_SSE       2
`define CPC_BIT_BSZ_HI    5
`define CPC_BIT_BSZ_LO    4
`define CPC_BIT_BLOCK0    0
`define CPC_BIT_BOOT      6
`define CPC_BIT_PC_HI     10
`define CPC_BIT_PC_MID    3
`define CPC_BIT_PC_LO     2
`define CPC_BIT_STEP_HI   4

// ----------------------------------------------------------------
// reset values, read answers and the boot area size unit
// ----------------------------------------------------------------
`define CPC_CFG_ERASED    8'hff
`define CPC_RD_UNMAPPED   8'hff
`define CPC_WORD_ZERO     16'h0000
`define CPC_BOOT_UNIT     22'h000200

`endif

// *** inc/cpc_pkg.sv ***
// types shared by the configuration protect block
package cpc_pkg;

  // operating mode, one-hot
  typedef enum logic [2:0] {
    CPC_RUN = 3'b001,
    CPC_LV  = 3'b010,
    CPC_HV  = 3'b100
  } cpc_mode_t;

  // configuration word access from the programmer
  typedef struct packed {
    logic       req;
    logic       we;
    logic [3:0] idx;
    logic [7:0] wdata;
  } cpc_cfg_req_t;

  typedef struct packed {
    logic       ack;
    logic       err;
    logic [7:0] rdata;
  } cpc_cfg_rsp_t;

  // code memory read, programmer or table read
  typedef struct packed {
    logic        valid;
    logic        is_table;
    logic [21:0] addr;
    logic [21:0] src_addr;
    logic [15:0] word;
  } cpc_rd_req_t;

  typedef struct packed {
    logic        ack;
    logic        denied;
    logic [15:0] data;
  } cpc_rd_rsp_t;

  // whole state of the top module
  typedef struct packed {
    cpc_mode_t    mode;
    logic [7:0]   cfg4l;
    logic [7:0]   code_lock;
    logic [7:0]   write_lock;
    logic [7:0]   trl_low;
    logic [7:0]   trl_high;
    cpc_cfg_rsp_t cfg_rsp;
    cpc_rd_rsp_t  rd_rsp;
    logic         gpio_en;
  } cpc_state_t;

endpackage

// *** hw/cpc_sync.sv ***
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module cpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } cpc_sync_t;

  cpc_sync_t s_reg;
  cpc_sync_t s_next;

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  // the first stage feeds only the second, never any logic
  always_comb begin
    s_next.first  = d;
    s_next.second = s_reg.first;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.second;

endmodule // cpc_sync

`default_nettype wire

// *** hw/cpc_top.sv ***
// configuration protect, identification and programming mode block
// ----------------------------------------------------------------
// How it works
// - block 0 locked to table reads from other blocks when its bit is 0
// - boot area locked to table reads from other blocks when its bit is 0
// - boot size writes ignored once any boot or block 0 lock is on
// - eleven-bit part code, high 8 in high word, low 3 in low word
// - five-bit silicon step reported in the low identification word
// - single-supply enable set means low-voltage programming; resets to 1
// - enable 0 makes select pin plain I/O; only high-voltage entry works
// - single-supply enable is writable only in high-voltage mode
// - high-voltage entry always accepted whatever the enable holds
// - select pin loses I/O function while low-voltage mode is active
// - unimplemented config bits read back as 1
// - code-locked blocks read back as all zeros
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "cpc_regs.svh"

module cpc_top #(
  // part identity, arbitrary values
  parameter logic [10:0] PART_CODE   = 11'h155,
  parameter logic [4:0]  SILICON_STEP = 5'h01,
  // last address of block 0
  parameter logic [21:0] BLOCK0_END  = 22'h001fff
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  high_program_voltage_level,
  input  wire logic                  program_select_pin,
  input  wire cpc_pkg::cpc_cfg_req_t cfg_req,
  output cpc_pkg::cpc_cfg_rsp_t      cfg_rsp,
  input  wire cpc_pkg::cpc_rd_req_t  rd_req,
  output cpc_pkg::cpc_rd_rsp_t       rd_rsp,
  output cpc_pkg::cpc_mode_t         prog_mode,
  output logic                       port_b_bit_five_gpio_en,
  output logic                       single_supply_enable,
  output logic [1:0]                 boot_area_size
);

  cpc_pkg::cpc_state_t st_reg;
  cpc_pkg::cpc_state_t st_next;

  logic [1:0] pins_sync;
  logic       hv_seen;
  logic       sel_seen;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  cpc_sync #(
    .W (2)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({high_program_voltage_level, program_select_pin}),
    .q     (pins_sync)
  );

  assign hv_seen  = pins_sync[1];
  assign sel_seen = pins_sync[0];

  // ----------------------------------------------------------------
  // decoded fields of the stored configuration words
  // ----------------------------------------------------------------
  logic        sse;
  logic [1:0]  bsz;
  logic        b0_code_lock;
  logic        boot_code_lock;
  logic        b0_wr_lock;
  logic        boot_wr_lock;
  logic        b0_trd_lock;
  logic        boot_trd_lock;
  logic        any_lock_on;
  logic [21:0] boot_end;

  // lock bits are active low: 0 means protected
  assign sse            = st_reg.cfg4l[`CPC_BIT_SSE];
  assign bsz            = st_reg.cfg4l[`CPC_BIT_BSZ_HI:`CPC_BIT_BSZ_LO];
  assign b0_code_lock   = st_reg.code_lock[`CPC_BIT_BLOCK0];
  assign boot_code_lock = st_reg.code_lock[`CPC_BIT_BOOT];
  assign b0_wr_lock     = st_reg.write_lock[`CPC_BIT_BLOCK0];
  assign boot_wr_lock   = st_reg.write_lock[`CPC_BIT_BOOT];
  assign b0_trd_lock    = st_reg.trl_low[`CPC_BIT_BLOCK0];
  assign boot_trd_lock  = st_reg.trl_high[`CPC_BIT_BOOT];

  // any cleared bit among the six freezes the boot size
  assign any_lock_on = !(b0_code_lock && boot_code_lock &&
                         b0_wr_lock && boot_wr_lock &&
                         b0_trd_lock && boot_trd_lock);

  // boot area doubles with each step of the size field
  assign boot_end = (`CPC_BOOT_UNIT << bsz) - 22'h000001;

  // ----------------------------------------------------------------
  // address classification for code reads
  // ----------------------------------------------------------------
  logic tgt_boot;
  logic tgt_b0;
  logic src_boot;
  logic src_b0;

  assign tgt_boot = rd_req.addr <= boot_end;
  assign tgt_b0   = !tgt_boot && (rd_req.addr <= BLOCK0_END);
  assign src_boot = rd_req.src_addr <= boot_end;
  assign src_b0   = !src_boot && (rd_req.src_addr <= BLOCK0_END);

  // ----------------------------------------------------------------
  // configuration word read-back
  // ----------------------------------------------------------------
  logic [7:0] cfg_view;
  logic       cfg_hit;

  // unimplemented positions are forced to 1 on read-back
  always_comb begin
    cfg_hit  = 1'b1;
    cfg_view = `CPC_RD_UNMAPPED;
    case (cfg_req.idx)
      `CPC_IDX_CFG4L: begin
        cfg_view = st_reg.cfg4l | ~`CPC_MASK_CFG4L;
      end
      `CPC_IDX_CODE_LOCK: begin
        cfg_view = st_reg.code_lock | ~`CPC_MASK_LOCK;
      end
      `CPC_IDX_WR_LOCK: begin
        cfg_view = st_reg.write_lock | ~`CPC_MASK_LOCK;
      end
      `CPC_IDX_TRL_LOW: begin
        cfg_view = st_reg.trl_low | ~`CPC_MASK_TRL_LOW;
      end
      `CPC_IDX_TRL_HIGH: begin
        cfg_view = st_reg.trl_high | ~`CPC_MASK_TRL_HIGH;
      end
      `CPC_IDX_PART_LOW: begin
        cfg_view = {PART_CODE[`CPC_BIT_PC_LO:0],
                    SILICON_STEP[`CPC_BIT_STEP_HI:0]};
      end
      `CPC_IDX_PART_HIGH: begin
        cfg_view = PART_CODE[`CPC_BIT_PC_HI:`CPC_BIT_PC_MID];
      end
      default: begin
        cfg_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       in_prog;
  logic       wr_ok;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic       trd_block;
  logic       code_zero;

  always_comb begin
    st_next = st_reg;
    in_prog = st_reg.mode != cpc_pkg::CPC_RUN;

    // mode selection: high voltage wins over everything
    case (st_reg.mode)
      cpc_pkg::CPC_RUN: begin
        if (hv_seen) begin
          st_next.mode = cpc_pkg::CPC_HV;
        end else if (sse && sel_seen) begin
          st_next.mode = cpc_pkg::CPC_LV;
        end
      end
      cpc_pkg::CPC_LV: begin
        if (hv_seen) begin
          st_next.mode = cpc_pkg::CPC_HV;
        end else if (!sel_seen || !sse) begin
          st_next.mode = cpc_pkg::CPC_RUN;
        end
      end
      cpc_pkg::CPC_HV: begin
        if (!hv_seen) begin
          st_next.mode = cpc_pkg::CPC_RUN;
        end
      end
      default: begin
        st_next.mode = cpc_pkg::CPC_RUN;
      end
    endcase

    // pin is plain I/O only when single-supply is off and not in use
    st_next.gpio_en = !sse && (st_reg.mode != cpc_pkg::CPC_LV);

    // configuration word access, writes only while programming
    st_next.cfg_rsp.ack   = cfg_req.req;
    st_next.cfg_rsp.err   = 1'b0;
    st_next.cfg_rsp.rdata = st_reg.cfg_rsp.rdata;
    wr_ok = cfg_req.req && cfg_req.we && in_prog && cfg_hit;
    wmask = 8'h00;
    wval  = cfg_req.wdata;
    if (cfg_req.req) begin
      st_next.cfg_rsp.rdata = cfg_view;
      st_next.cfg_rsp.err   = !cfg_hit ||
                              (cfg_req.we && !in_prog);
    end
    if (wr_ok) begin
      case (cfg_req.idx)
        `CPC_IDX_CFG4L: begin
          wmask = `CPC_MASK_CFG4L;
          // single-supply bit changes only under high voltage
          if (st_reg.mode != cpc_pkg::CPC_HV) begin
            wval[`CPC_BIT_SSE] = sse;
          end
          // frozen boot size keeps its old value
          if (any_lock_on) begin
            wval[`CPC_BIT_BSZ_HI:`CPC_BIT_BSZ_LO] = bsz;
          end
          st_next.cfg4l = (wval & wmask) | ~wmask;
        end
        `CPC_IDX_CODE_LOCK: begin
          wmask = `CPC_MASK_LOCK;
          st_next.code_lock = (wval & wmask) | ~wmask;
        end
        `CPC_IDX_WR_LOCK: begin
          wmask = `CPC_MASK_LOCK;
          st_next.write_lock = (wval & wmask) | ~wmask;
        end
        `CPC_IDX_TRL_LOW: begin
          wmask = `CPC_MASK_TRL_LOW;
          st_next.trl_low = (wval & wmask) | ~wmask;
        end
        `CPC_IDX_TRL_HIGH: begin
          wmask = `CPC_MASK_TRL_HIGH;
          st_next.trl_high = (wval & wmask) | ~wmask;
        end
        default: begin
          // identification words are read-only
          st_next.cfg_rsp.err = 1'b1;
        end
      endcase
    end

    // code memory reads
    trd_block = rd_req.is_table &&
                ((tgt_b0 && !src_b0 && !b0_trd_lock) ||
                 (tgt_boot && !src_boot && !boot_trd_lock));
    code_zero = !rd_req.is_table &&
                ((tgt_b0 && !b0_code_lock) ||
                 (tgt_boot && !boot_code_lock));
    st_next.rd_rsp.ack    = rd_req.valid;
    st_next.rd_rsp.denied = rd_req.valid && trd_block;
    if (rd_req.valid) begin
      // protected words read as zero so they add nothing to a sum
      if (trd_block || code_zero) begin
        st_next.rd_rsp.data = `CPC_WORD_ZERO;
      end else begin
        st_next.rd_rsp.data = rd_req.word;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // configuration words come up erased: unprotected, single-supply on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg.mode       <= cpc_pkg::CPC_RUN;
      st_reg.cfg4l      <= `CPC_CFG_ERASED;
      st_reg.code_lock  <= `CPC_CFG_ERASED;
      st_reg.write_lock <= `CPC_CFG_ERASED;
      st_reg.trl_low    <= `CPC_CFG_ERASED;
      st_reg.trl_high   <= `CPC_CFG_ERASED;
      st_reg.cfg_rsp    <= '0;
      st_reg.rd_rsp     <= '0;
      st_reg.gpio_en    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  assign cfg_rsp                 = st_reg.cfg_rsp;
  assign rd_rsp                  = st_reg.rd_rsp;
  assign prog_mode               = st_reg.mode;
  assign port_b_bit_five_gpio_en = st_reg.gpio_en;
  assign single_supply_enable    = sse;
  assign boot_area_size          = bsz;

endmodule // cpc_top

`default_nettype wire

// *** tb/cpc_top_asserts.sv ***
// port checker for the configuration protect block
`timescale 1ns/1ps
`default_nettype none

module cpc_top_asserts #(
  parameter logic [10:0] PART_CODE    = 11'h155,
  parameter logic [4:0]  SILICON_STEP = 5'h01
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  high_program_voltage_level,
  input wire cpc_pkg::cpc_cfg_req_t cfg_req,
  input wire cpc_pkg::cpc_cfg_rsp_t cfg_rsp,
  input wire cpc_pkg::cpc_rd_req_t  rd_req,
  input wire cpc_pkg::cpc_rd_rsp_t  rd_rsp,
  input wire cpc_pkg::cpc_mode_t    prog_mode,
  input wire logic                  port_b_bit_five_gpio_en,
  input wire logic                  single_supply_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // --------------------
  // port answers
  // --------------------
  property p_cfg_ack; cfg_req.req |=> cfg_rsp.ack; endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("no ack");
  property p_rd_deny;
    rd_req.valid |=> rd_rsp.ack && (!rd_rsp.denied || rd_rsp.data == 16'h0);
  endproperty
  a_rd_deny: assert property (p_rd_deny) else $error("bad read");
  property p_part_low;
    cfg_rsp.ack && $past(cfg_req.idx) == 4'h5 && !$past(cfg_req.we)
      |-> cfg_rsp.rdata == {PART_CODE[2:0], SILICON_STEP};
  endproperty
  a_part_low: assert property (p_part_low) else $error("low id");
  property p_part_high;
    cfg_rsp.ack && $past(cfg_req.idx) == 4'h6 && !$past(cfg_req.we)
      |-> cfg_rsp.rdata == PART_CODE[10:3];
  endproperty
  a_part_high: assert property (p_part_high) else $error("high id");

  // --------------------
  // programming modes
  // --------------------
  // the pin passes two sync stages, so four samples reach the mode
  property p_hv;
    high_program_voltage_level [*4] |-> prog_mode == cpc_pkg::CPC_HV;
  endproperty
  a_hv: assert property (p_hv) else $error("no hv entry");
  property p_sse_hold;
    prog_mode != cpc_pkg::CPC_HV |=> $stable(single_supply_enable);
  endproperty
  a_sse_hold: assert property (p_sse_hold) else $error("sse moved");
  property p_lv_pin;
    prog_mode == cpc_pkg::CPC_LV [*2] |-> !port_b_bit_five_gpio_en;
  endproperty
  a_lv_pin: assert property (p_lv_pin) else $error("pin free in lv");
  property p_io_pin;
    (!single_supply_enable && prog_mode != cpc_pkg::CPC_LV) [*2]
      |-> port_b_bit_five_gpio_en;
  endproperty
  a_io_pin: assert property (p_io_pin) else $error("pin not io");
endmodule // cpc_top_asserts

bind cpc_top cpc_top_asserts #(
  .PART_CODE    (PART_CODE),
  .SILICON_STEP (SILICON_STEP)
) u_chk (
  .clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
  .high_program_voltage_level(high_program_voltage_level),
  .rd_req(rd_req), .rd_rsp(rd_rsp), .prog_mode(prog_mode),
  .port_b_bit_five_gpio_en(port_b_bit_five_gpio_en),
  .single_supply_enable(single_supply_enable)
);
`default_nettype wire

// *** tb/cpc_prog_model.sv ***
// programmer model driving the programming port of the block
`timescale 1ns/1ps
`default_nettype none

module cpc_prog_model (
  input  wire logic                  clk,
  output cpc_pkg::cpc_cfg_req_t      cfg_req,
  input  wire cpc_pkg::cpc_cfg_rsp_t cfg_rsp,
  output cpc_pkg::cpc_rd_req_t       rd_req,
  input  wire cpc_pkg::cpc_rd_rsp_t  rd_rsp,
  output logic                       hv_level,
  output logic                       select_level
);
  localparam int CFG_IMG = 'h300000; // config words in the saved image
  localparam int EE_IMG  = 'hf00000; // data EEPROM in the saved image
  logic [7:0]  image [int];
  logic [15:0] csum;
  logic        prot_seen;

  // idle fields carry junk so a stale value never passes for a live one
  initial begin
    cfg_req = {1'b0, 13'($urandom)};
    rd_req = {1'b0, 61'($urandom)};
    hv_level = 1'b0;
    select_level = 1'b0;
    csum = 16'h0000;
    prot_seen = 1'b0;
  end

  // implemented-bit masks of the five configuration words
  function automatic logic [7:0] cfg_mask(input logic [3:0] idx);
    case (idx)
      4'h0: return 8'h34;
      4'h1, 4'h2: return 8'h41;
      4'h3: return 8'h01;
      default: return 8'h40;
    endcase
  endfunction

  // a new checksum starts from zero
  task automatic csum_clear();
    csum = 16'h0000;
  endtask

  // ID words count only when some block reads back code-protected
  task automatic sum_id(input logic [15:0] w);
    if (prot_seen) csum = csum + w;
  endtask

  // data EEPROM goes into the image but never into the sum
  task automatic ee_save(input int off, input logic [7:0] b);
    image[EE_IMG + off] = b;
  endtask

  // both pin levels are driven together at a falling edge
  task automatic pins(input logic hv, input logic sel);
    @(negedge clk);
    hv_level = hv;
    select_level = sel;
  endtask

  // request held over one rising edge; the answer stands one cycle only,
  // so it is taken at the next falling edge
  task automatic cfg(input logic we, input logic [3:0] idx,
                     input logic [7:0] wd, output logic [8:0] rsp);
    @(negedge clk);
    cfg_req = {1'b1, we, idx, wd};
    @(negedge clk);
    rsp = cfg_rsp.ack ? {cfg_rsp.err, cfg_rsp.rdata} : 9'bx;
    cfg_req = {1'b0, 13'($urandom)};
    if (!we && idx < 4'h5) begin
      image[CFG_IMG + 32'(idx)] = rsp[7:0];
      csum = csum + 16'(rsp[7:0] & cfg_mask(idx));
      if (idx == 4'h1) prot_seen = !(rsp[0] && rsp[6]);
    end
  endtask

  // one 16-bit word per read, flash contents supplied by the caller
  task automatic rd(input logic tbl, input logic [21:0] a,
                    input logic [21:0] s, input logic [15:0] w,
                    output logic [16:0] rsp);
    @(negedge clk);
    rd_req = {1'b1, tbl, a, s, w};
    @(negedge clk);
    rsp = rd_rsp.ack ? {rd_rsp.denied, rd_rsp.data} : 17'bx;
    rd_req = {1'b0, 61'($urandom)};
    // 16-bit sum, carries out of bit 15 fall away
    if (!tbl) csum = csum + rsp[15:0];
  endtask
endmodule // cpc_prog_model
`default_nettype wire

// *** tb/cpc_top_bench.sv ***
// self-checking bench for the configuration protect block
`timescale 1ns/1ps
`default_nettype none

module cpc_top_bench;
  localparam logic [10:0] PC = 11'h2a3; // arbitrary identity value
  localparam logic [4:0]  ST = 5'h12;   // arbitrary identity value
  localparam int          B0E = 32'h1fff;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  hv;
  logic                  sel;
  logic                  gpio_en;
  logic                  sse;
  logic [1:0]            bsz;
  logic [8:0]            cr;
  logic [16:0]           rr;
  cpc_pkg::cpc_cfg_req_t cfg_req;
  cpc_pkg::cpc_cfg_rsp_t cfg_rsp;
  cpc_pkg::cpc_rd_req_t  rd_req;
  cpc_pkg::cpc_rd_rsp_t  rd_rsp;
  cpc_pkg::cpc_mode_t    prog_mode;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  int                    es = 0;
  int                    cfgw[5] = '{'hff, 'hff, 'hff, 'hff, 'hff};
  int                    msk[5] = '{'h34, 'h41, 'h41, 'h01, 'h40};

  always #25 clk = ~clk;

  cpc_top #(.PART_CODE(PC), .SILICON_STEP(ST), .BLOCK0_END(B0E[21:0])) u_dut (
    .clk(clk), .rst_n(rst_n), .high_program_voltage_level(hv),
    .program_select_pin(sel), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .rd_req(rd_req), .rd_rsp(rd_rsp), .prog_mode(prog_mode),
    .port_b_bit_five_gpio_en(gpio_en), .single_supply_enable(sse),
    .boot_area_size(bsz));

  cpc_prog_model u_prog (
    .clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .rd_req(rd_req),
    .rd_rsp(rd_rsp), .hv_level(hv), .select_level(sel));

  // --------------------
  // comparisons and verdict
  // --------------------
  task automatic cmp(input logic [16:0] g, input logic [16:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_cfg(input logic [8:0] g, e); cmp(17'(g), 17'(e)); endtask
  task automatic chk_rd(input logic [16:0] g, e); cmp(g, e); endtask
  task automatic chk_out(input logic [7:0] g, e); cmp(17'(g), 17'(e)); endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // --------------------
  // reference model
  // --------------------
  // any boot or block 0 protection bit at 0 freezes the boot size
  function automatic bit locked();
    return !(cfgw[1][0] && cfgw[1][6] && cfgw[2][0] && cfgw[2][6] &&
             cfgw[3][0] && cfgw[4][6]);
  endfunction

  // 0 boot area, 1 block 0, 2 beyond
  function automatic int region(input int a);
    if (a < (32'h200 << ((cfgw[0] >> 4) & 3))) return 0;
    return a <= B0E ? 1 : 2;
  endfunction

  // a write answers with the old contents
  task automatic wr(input int i, input int wd, input bit hv_on);
    int v;
    v = (wd | ~msk[i]) & 'hff;
    if (i == 0 && !hv_on) v[2] = cfgw[0][2];
    if (i == 0 && locked()) v[5:4] = cfgw[0][5:4];
    u_prog.cfg(1'b1, 4'(i), 8'(wd), cr);
    chk_cfg(cr, {1'b0, 8'(cfgw[i])});
    cfgw[i] = v;
  endtask

  task automatic rd_cfg(input int i);
    u_prog.cfg(1'b0, 4'(i), 8'h00, cr);
    chk_cfg(cr, {1'b0, 8'(cfgw[i])});
  endtask

  task automatic rd_code(input bit t, input int a, input int s, input int w);
    int ra;
    bit dn;
    ra = region(a);
    dn = t && ra != region(s) && (ra == 1 && !cfgw[3][0] ||
                                  ra == 0 && !cfgw[4][6]);
    if (dn || !t && (ra == 1 && !cfgw[1][0] || ra == 0 && !cfgw[1][6]))
      w = 0;
    u_prog.rd(t, 22'(a), 22'(s), 16'(w), rr);
    chk_rd(rr, {dn, 16'(w)});
    if (!t) es += w;
  endtask

  // --------------------
  // scenarios
  // --------------------
  initial begin
    void'($urandom(60447));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // erased words, identity words, an unmapped word
    for (int i = 0; i < 5; i++) rd_cfg(i);
    u_prog.cfg(1'b0, 4'h5, 8'h00, cr);
    chk_cfg(cr, {1'b0, PC[2:0], ST});
    u_prog.cfg(1'b0, 4'h6, 8'h00, cr);
    chk_cfg(cr, {1'b0, PC[10:3]});
    u_prog.cfg(1'b0, 4'h9, 8'h00, cr);
    chk_cfg(cr, 9'h1ff);
    chk_out({sse, bsz}, 3'b111);
    // a write outside programming is refused and leaves the word
    u_prog.cfg(1'b1, 4'h0, 8'h00, cr);
    chk_cfg(cr, 9'h1ff);
    rd_cfg(0);
    // low-voltage entry; the enable bit cannot be cleared here
    u_prog.pins(1'b0, 1'b1);
    repeat (4) @(negedge clk);
    chk_out({prog_mode, gpio_en}, {cpc_pkg::CPC_LV, 1'b0});
    wr(0, 0, 0);
    chk_out({sse, bsz}, 3'b100);
    u_prog.cfg(1'b1, 4'h5, 8'h00, cr);
    chk_cfg(cr[8], 9'h001);
    // high-voltage entry, then every table lock setting under reads
    u_prog.pins(1'b1, 1'b0);
    repeat (4) @(negedge clk);
    chk_out(prog_mode, cpc_pkg::CPC_HV);
    for (int k = 0; k < 4; k++) begin
      wr(3, k, 1);
      wr(4, k << 5, 1);
      wr(1, $urandom, 1);
      for (int j = 0; j < 12; j++)
        rd_code($urandom % 2, $urandom % 'h4000, $urandom % 'h4000,
                $urandom);
    end
    // boot size frozen under a lock while the enable bit is cleared
    wr(3, 0, 1);
    wr(0, 'h30, 1);
    chk_out({sse, bsz}, 3'b000);
    // enable off: select pin is plain I/O, only high voltage enters
    u_prog.pins(1'b0, 1'b1);
    repeat (4) @(negedge clk);
    chk_out({prog_mode, gpio_en}, {cpc_pkg::CPC_RUN, 1'b1});
    u_prog.pins(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    chk_out(prog_mode, cpc_pkg::CPC_HV);
    // programmer checksum over the device's read-back as locks stand
    u_prog.csum_clear();
    es = 0;
    for (int i = 0; i < 5; i++) begin
      rd_cfg(i);
      es += cfgw[i] & msk[i];
    end
    for (int a = 0; a < 'h4000; a += 'h80) rd_code(0, a, 0, $urandom);
    u_prog.sum_id(16'h1234);
    if (!cfgw[1][0] || !cfgw[1][6]) es += 'h1234;
    u_prog.ee_save(0, 8'h5a);
    chk_rd({1'b0, u_prog.csum}, {1'b0, 16'(es)});
    chk_out(u_prog.image['h300000], 8'(cfgw[0]));
    chk_out(u_prog.image['hf00000], 8'h5a);
    finish_test();
  end

  // a hung access ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule // cpc_top_bench
`default_nettype wire
